//--- rtl/clr_ops_defines.svh
// offsets, field positions, reset values and opcodes of the executor
// assumes inclusion by bare name from the package, op_exec, the top module and the test
`ifndef CLR_OPS_DEFINES_SVH
`define CLR_OPS_DEFINES_SVH

// register word indices (byte address = 4 * index)
`define IDX_INSTR       3'h0
`define IDX_ACC         3'h1
`define IDX_STATUS      3'h2
`define IDX_WDOG        3'h3
`define IDX_FILE_INDEX  3'h4
`define IDX_FILE_DATA   3'h5

// status register bit positions
`define STAT_NULL_BIT   0
`define STAT_SLEEP_BIT  1
`define STAT_EXPIRY_BIT 2

// watchdog readback field positions
`define WDOG_CNT_LSB    0
`define WDOG_PRE_LSB    8

// reset values
`define ACC_RST         8'h00
`define NULL_RST        1'b0
`define SLEEP_N_RST     1'b1
`define EXPIRY_N_RST    1'b1
`define WDOG_RST        8'h00
`define INSTR_RST       14'h0000

// instruction word layout
`define INSTR_W         14
`define OPC_MSB         13
`define OPC_LSB         8
`define DEST_BIT        7
`define FIDX_MSB        6

// opcodes
`define OPC_CLEAR_ACC   14'h0103
`define OPC_WDOG        14'h0064
`define OPC_DEC         6'h03
`define OPC_INV         6'h09

// constant results
`define RESULT_ZERO     8'h00
`define WDOG_TOP        8'hFF

`endif

//--- rtl/clr_ops_pkg.sv
// types shared by the executor and its top module
// assumes clr_ops_defines.svh sits beside it
package clr_ops_pkg;
`include "clr_ops_defines.svh"

   typedef enum logic [2:0] {
      OP_NONE,
      OP_CLEAR_ACC,
      OP_WDOG,
      OP_DEC,
      OP_INV
   } op_e;

   typedef struct packed {
      op_e        op;
      logic       acc_we;
      logic [7:0] acc_val;
      logic       file_we;
      logic [7:0] file_val;
      logic       null_we;
      logic       null_val;
      logic       wdog_restart;
   } exec_s;

endpackage : clr_ops_pkg

//--- rtl/op_exec.sv
// combinational decode and result path of the four operations
// assumes one instruction word, the accumulator and the selected operand
`include "clr_ops_defines.svh"
module op_exec
   import clr_ops_pkg::*;
(
   input  wire logic [13:0]        instr,
   input  wire logic [7:0]         acc,
   input  wire logic [7:0]         operand,
   output clr_ops_pkg::exec_s      result
);

   function automatic op_e decode_op(input logic [13:0] w);
      op_e o;
      o = OP_NONE;
      if (w == `OPC_CLEAR_ACC)
         o = OP_CLEAR_ACC;
      else if (w == `OPC_WDOG)
         o = OP_WDOG;
      else if (w[`OPC_MSB:`OPC_LSB] == `OPC_DEC)
         o = OP_DEC;
      else if (w[`OPC_MSB:`OPC_LSB] == `OPC_INV)
         o = OP_INV;
      return o;
   endfunction : decode_op

   logic [7:0] value;

   always_comb
   begin
      result = '0;
      result.op = decode_op(instr);
      result.acc_val = acc;
      result.file_val = operand;
      value = operand;
      unique case (result.op)
         OP_CLEAR_ACC:
         begin
            result.acc_we   = 1'b1;
            result.acc_val  = `RESULT_ZERO;
            result.null_we  = 1'b1;
            result.null_val = 1'b1;
         end
         OP_WDOG:
            result.wdog_restart = 1'b1;
         OP_DEC, OP_INV:
         begin
            if (result.op == OP_DEC)
               value = operand - 8'h01;
            else
               value = ~operand;
            result.acc_we   = ~instr[`DEST_BIT];
            result.file_we  = instr[`DEST_BIT];
            result.acc_val  = value;
            result.file_val = value;
            result.null_we  = 1'b1;
            result.null_val = (value == `RESULT_ZERO);
         end
         OP_NONE:
            result.op = OP_NONE;
      endcase
   end

endmodule : op_exec

//--- rtl/clr_ops_top.sv
// instruction executor with accumulator, file, status and watchdog
// assumes an Avalon-MM master on the same clock, word addressing
//
// Added by the designer: the Avalon-MM register port and the address map.
`include "clr_ops_defines.svh"
module clr_ops_top
   import clr_ops_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [7:0]  accumulator,
   output logic             result_null,
   output logic             watchdog_expiry_n,
   output logic             sleep_entry_n
);
   import clr_ops_pkg::*;

   logic [7:0]  file_mem [128];
   logic [7:0]  acc_reg;
   logic        null_reg;
   logic        expiry_n_reg;
   logic        sleep_n_reg;
   logic [7:0]  watchdog_counter;
   logic [7:0]  prescaler_reg;
   logic [13:0] instr_reg;
   logic [6:0]  fidx_reg;
   logic [31:0] rdata_reg;
   logic        rd_done_reg;
   logic        rd_done_next;

   logic        wr_ok;
   logic        exec_go;
   logic [13:0] exec_word;
   logic [6:0]  exec_f;
   logic [7:0]  operand;
   exec_s       res;
   logic        do_dec_inv;
   logic        wdog_tick;
   logic        wdog_wrap;
   logic        sw_stat_wr;

   function automatic logic [31:0] read_mux(input logic [2:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         `IDX_INSTR:      d = {18'h00000, instr_reg};
         `IDX_ACC:        d = {24'h000000, acc_reg};
         `IDX_STATUS:     d = {29'h00000000, expiry_n_reg,
                               sleep_n_reg, null_reg};
         `IDX_WDOG:       d = {16'h0000, prescaler_reg,
                               watchdog_counter};
         `IDX_FILE_INDEX: d = {25'h0000000, fidx_reg};
         `IDX_FILE_DATA:  d = {24'h000000, file_mem[fidx_reg]};
         default:         d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_mux

   // writes never wait, reads take one wait cycle
   assign wr_ok           = avs_write & avs_byteenable[0];
   assign rd_done_next    = avs_read & ~rd_done_reg;
   assign avs_waitrequest = avs_read & ~rd_done_reg;
   assign avs_readdata    = rdata_reg;

   // an instruction write executes in the cycle it is accepted
   assign exec_go   = wr_ok & (avs_address == `IDX_INSTR);
   assign exec_word = avs_writedata[13:0];
   assign exec_f    = exec_word[`FIDX_MSB:0];
   assign operand   = file_mem[exec_f];
   assign sw_stat_wr = wr_ok & (avs_address == `IDX_STATUS);
   assign do_dec_inv = exec_go & ((res.op == OP_DEC) | (res.op == OP_INV));

   op_exec u_exec (
      .instr   (exec_word),
      .acc     (acc_reg),
      .operand (operand),
      .result  (res)
   );

   assign accumulator       = acc_reg;
   assign result_null       = null_reg;
   assign watchdog_expiry_n = expiry_n_reg;
   assign sleep_entry_n     = sleep_n_reg;

   // read data
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_done_reg <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
      end
      else
      begin
         rd_done_reg <= rd_done_next;
         if (rd_done_next)
            rdata_reg <= read_mux(avs_address);
      end
   end

   // instruction and index registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         instr_reg <= `INSTR_RST;
         fidx_reg  <= 7'h00;
      end
      else
      begin
         if (exec_go)
            instr_reg <= exec_word;
         if (wr_ok && avs_address == `IDX_FILE_INDEX)
            fidx_reg <= avs_writedata[6:0];
      end
   end

   // accumulator
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         acc_reg <= `ACC_RST;
      else if (exec_go && res.acc_we)
         acc_reg <= res.acc_val;
      else if (wr_ok && avs_address == `IDX_ACC)
         acc_reg <= avs_writedata[7:0];
   end

   // file registers, no reset
   always_ff @(posedge clock)
   begin
      if (exec_go && res.file_we)
         file_mem[exec_f] <= res.file_val;
      else if (wr_ok && avs_address == `IDX_FILE_DATA)
         file_mem[fidx_reg] <= avs_writedata[7:0];
   end

   // result-null flag
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         null_reg <= `NULL_RST;
      else if (exec_go && res.null_we)
         null_reg <= res.null_val;
      else if (sw_stat_wr)
         null_reg <= avs_writedata[`STAT_NULL_BIT];
   end

   // watchdog prescaler and counter
   assign wdog_tick = (prescaler_reg == `WDOG_TOP);
   assign wdog_wrap = wdog_tick & (watchdog_counter == `WDOG_TOP);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         prescaler_reg    <= `WDOG_RST;
         watchdog_counter <= `WDOG_RST;
      end
      else if (exec_go && res.wdog_restart)
      begin
         watchdog_counter <= `WDOG_RST;
         prescaler_reg    <= `WDOG_RST;
      end
      else
      begin
         prescaler_reg <= prescaler_reg + 8'h01;
         if (wdog_tick)
            watchdog_counter <= watchdog_counter + 8'h01;
      end
   end

   // expiry and sleep status, hardware events win over software writes
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         expiry_n_reg <= `EXPIRY_N_RST;
         sleep_n_reg  <= `SLEEP_N_RST;
      end
      else if (exec_go && res.wdog_restart)
      begin
         expiry_n_reg <= 1'b1;
         sleep_n_reg  <= 1'b1;
      end
      else
      begin
         if (wdog_wrap)
            expiry_n_reg <= 1'b0;
         else if (sw_stat_wr)
            expiry_n_reg <= avs_writedata[`STAT_EXPIRY_BIT];
         if (sw_stat_wr)
            sleep_n_reg <= avs_writedata[`STAT_SLEEP_BIT];
      end
   end

   AST_CLEAR_ACC: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_CLEAR_ACC |=> acc_reg == 8'h00 && null_reg)
      else $error("clear did not zero accumulator and set null");

   AST_WDOG_CNT: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_WDOG |=> watchdog_counter == 8'h00
         ##1 watchdog_counter == 8'h00)
      else $error("watchdog counter not restarted");

   AST_WDOG_PRE: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_WDOG |=> prescaler_reg == 8'h00
         ##1 prescaler_reg <= 8'h01)
      else $error("prescaler not restarted with counter");

   AST_WDOG_STATUS: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_WDOG |=> expiry_n_reg && sleep_n_reg)
      else $error("restart did not set status bits");

   AST_DEC_FILE: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_DEC && exec_word[`DEST_BIT]
      |=> file_mem[$past(exec_f)] == $past(operand) - 8'h01)
      else $error("decrement result wrong");

   AST_DEST_ACC: assert property (@(posedge clock) disable iff (!nrst)
      do_dec_inv && !exec_word[`DEST_BIT]
      |=> file_mem[$past(exec_f)] == $past(operand)
          && acc_reg == (($past(res.op) == OP_DEC)
                         ? $past(operand) - 8'h01 : ~$past(operand)))
      else $error("accumulator target disturbed the source");

   AST_DEST_FILE: assert property (@(posedge clock) disable iff (!nrst)
      do_dec_inv && exec_word[`DEST_BIT] |=> $stable(acc_reg))
      else $error("file target changed the accumulator");

   AST_INV: assert property (@(posedge clock) disable iff (!nrst)
      exec_go && res.op == OP_INV && !exec_word[`DEST_BIT]
      |=> acc_reg == ~$past(operand))
      else $error("invert result wrong");

   AST_NULL: assert property (@(posedge clock) disable iff (!nrst)
      do_dec_inv |=> null_reg == (($past(operand) == 8'h01
         && $past(res.op) == OP_DEC) || ($past(operand) == 8'hFF
         && $past(res.op) == OP_INV)))
      else $error("null flag does not match result");

   AST_ONE_CYCLE: assert property (@(posedge clock) disable iff (!nrst)
      exec_go |-> !avs_waitrequest ##1 instr_reg == $past(exec_word))
      else $error("instruction not taken in one cycle");

endmodule : clr_ops_top

//--- tb/fetch_model.sv
// bus master standing in for the core fetch logic
// assumes an avalon-mm slave with waitrequest on the same clock
module fetch_model
(
   input  wire logic        clock,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic      [2:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable
);
   timeunit 1ns;
   timeprecision 1ps;

   int waits;

   initial
   begin
      waits          = 0;
      avs_address    = 3'h0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hF;
   end

   // hold keeps write high for a back-to-back write
   task wr(input logic [2:0] a, input logic [31:0] d, input bit hold);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do
         @(posedge clock);
      while (avs_waitrequest === 1'b1);
      if (!hold)
      begin
         avs_write <= 1'b0;
         @(posedge clock);
      end
   endtask : wr

   task rd(input logic [2:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read    <= 1'b1;
      waits = 0;
      do
      begin
         @(posedge clock);
         waits++;
      end
      while (avs_waitrequest === 1'b1);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : rd
endmodule : fetch_model

//--- tb/clear_decrement_complement_ops_test.sv
// self-checking bench of the executor, with a behavioural result model
// assumes fetch_model drives the register bus
`include "clr_ops_defines.svh"
module clear_decrement_complement_ops_test;
   timeunit 1ns;
   timeprecision 1ps;
   import clr_ops_pkg::*;

   logic        clock;
   logic        nrst;
   logic [2:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  accumulator;
   logic        result_null;
   logic        watchdog_expiry_n;
   logic        sleep_entry_n;
   logic [31:0] d;
   int          err_count;
   int          check_count;
   int          n;
   int          am;
   int          fm;
   int          v;
   int          r;
   int          idx;
   bit          inv;

   clr_ops_top i_clr_ops_top
   (
      .clock             (clock),
      .nrst              (nrst),
      .avs_address       (avs_address),
      .avs_read          (avs_read),
      .avs_write         (avs_write),
      .avs_writedata     (avs_writedata),
      .avs_byteenable    (avs_byteenable),
      .avs_readdata      (avs_readdata),
      .avs_waitrequest   (avs_waitrequest),
      .accumulator       (accumulator),
      .result_null       (result_null),
      .watchdog_expiry_n (watchdog_expiry_n),
      .sleep_entry_n     (sleep_entry_n)
   );

   fetch_model i_fetch_model
   (
      .clock           (clock),
      .avs_waitrequest (avs_waitrequest),
      .avs_readdata    (avs_readdata),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable)
   );

   initial
   begin
      clock = 1'b0;
      forever
         #2 clock = ~clock;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (100000) @(posedge clock);
      err_count++;
      complete_run();
   end

   initial
   begin
      nrst = 1'b0;
      void'($urandom(60));
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      i_fetch_model.rd(`IDX_STATUS, d);
      check(d, 32'h6);
      check(i_fetch_model.waits, 2);
      // let the watchdog run out
      n = 0;
      while (watchdog_expiry_n !== 1'b0 && n < 70000)
      begin
         @(posedge clock);
         n++;
      end
      check(watchdog_expiry_n, 1'b0);
      i_fetch_model.wr(`IDX_STATUS, 32'h1, 0);
      i_fetch_model.wr(`IDX_INSTR, {18'h0, `OPC_WDOG}, 0);
      check(watchdog_expiry_n, 1'b1);
      check(sleep_entry_n, 1'b1);
      check(result_null, 1'b1);
      i_fetch_model.rd(`IDX_WDOG, d);
      check(d[7:0], 8'h00);
      check(d[15:8] < 8'h08, 1'b1);
      // clear accumulator
      i_fetch_model.wr(`IDX_ACC, 32'h5A, 0);
      i_fetch_model.wr(`IDX_STATUS, 32'h6, 0);
      i_fetch_model.wr(`IDX_INSTR, {18'h0, `OPC_CLEAR_ACC}, 0);
      check(accumulator, 8'h00);
      check(result_null, 1'b1);
      i_fetch_model.rd(`IDX_INSTR, d);
      check(d, 32'h0103);
      // decrement and invert, both targets, zero results first
      for (int i = 0; i < 16; i++)
      begin
         inv = i[0];
         idx = $urandom % 128;
         v = (i < 4) ? (inv ? 8'hFF : 8'h01) : $urandom % 256;
         am = $urandom % 256;
         fm = v;
         i_fetch_model.wr(`IDX_FILE_INDEX, idx, 0);
         i_fetch_model.wr(`IDX_FILE_DATA, v, 0);
         i_fetch_model.wr(`IDX_ACC, am, 0);
         r = inv ? (~v & 8'hFF) : ((v - 1) & 8'hFF);
         if (i[1])
            fm = r;
         else
            am = r;
         i_fetch_model.wr(`IDX_INSTR,
            {18'h0, inv ? `OPC_INV : `OPC_DEC, i[1], idx[6:0]}, 0);
         check(accumulator, am);
         check(result_null, r == 0);
         i_fetch_model.rd(`IDX_FILE_DATA, d);
         check(d, fm);
      end
      // back-to-back: decrement into file, then invert into accumulator
      i_fetch_model.wr(`IDX_FILE_DATA, 32'h10, 0);
      i_fetch_model.wr(`IDX_INSTR, {18'h0, `OPC_DEC, 1'b1, idx[6:0]}, 1);
      i_fetch_model.wr(`IDX_INSTR, {18'h0, `OPC_INV, 1'b0, idx[6:0]}, 0);
      check(accumulator, 8'hF0);
      check(result_null, 1'b0);
      i_fetch_model.rd(`IDX_FILE_DATA, d);
      check(d, 32'h0F);
      // unmapped place
      i_fetch_model.wr(3'h6, 32'hFFFFFFFF, 0);
      i_fetch_model.rd(3'h6, d);
      check(d, 32'h0);
      complete_run();
   end
endmodule : clear_decrement_complement_ops_test
